/* bench/cci_sys_model.sv */
// Far side of the pin-control block: a slow or prompt bus peripheral
// and the keepers that hold floated pins at logic one.
// Assumes the package is compiled first and one shared clock.
`timescale 1ns/1ps

module cci_sys_model (
    // Clock.
    input  wire logic                 clock,
    // Design side.
    input  wire cci_pkg::cci_bus_st_t bus_state,
    input  wire cci_pkg::cci_pin_t    io_mem_pin,
    input  wire cci_pkg::cci_pin_t    write_n_pin,
    input  wire logic [1:0]           slow,
    // Far side.
    output logic                      ready_pin,
    output logic                      io_mem_wire,
    output logic                      write_n_wire
);
    logic [1:0] cnt_q = 2'h0; // Cycles of not-ready still to give.

    ////////////////////////////////////////////////////////////////
    // Ready drops at T1 for a chosen span, so wait states follow.
    always @(posedge clock) begin
        if (bus_state == cci_pkg::CCI_T1) begin
            cnt_q <= slow;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    // The peripheral decodes its select in T1, so ready is already low
    // there and reaches the synchroniser in time for the T3 decision.
    assign ready_pin = (cnt_q == 2'h0) && !(bus_state == cci_pkg::CCI_T1 && slow != 2'h0);

    // A released pin is held at logic one by the bus keeper.
    assign io_mem_wire  = io_mem_pin.oe_n ? 1'h1 : io_mem_pin.lvl;
    assign write_n_wire = write_n_pin.oe_n ? 1'h1 : write_n_pin.lvl;
endmodule

/* bench/tb_top.sv */
// Self-checking bench of the pin-control block with a peripheral model.
// Assumes the package, header and design sit in rtl/.
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {logic io; logic wr;} cci_tb_bus_t;
    logic clock, nrst, maskable_irq, nmi_pin, test_n_pin, ready_pin;
    logic hold_pin, mode_select_input, maskable_irq_enable, instr_boundary;
    logic wait_instr, bus_req, bus_is_io, bus_is_write, bus_accept;
    logic bus_done, core_stall, core_restart, min_mode, bus_grant_output;
    logic io_mem_wire, write_n_wire, exp_io;
    logic [7:0] maskable_irq_type, wr_lo, n_tw;
    logic [1:0] slow;
    logic [31:0] rnd = 32'hC275;
    cci_pkg::cci_bus_st_t bus_state;
    cci_pkg::cci_irq_t irq_report;
    cci_pkg::cci_pin_t io_mem_pin, write_n_pin;
    cci_tb_bus_t bq[$];        // Expected bus cycles.
    cci_pkg::cci_irq_t iq[$];  // Expected interrupt reports.
    int n_mismatch = 0;
    int comparisons = 0;

    cci_ctrl i_cci_ctrl (.clock(clock), .nrst(nrst), .maskable_irq(maskable_irq),
        .nmi_pin(nmi_pin), .test_n_pin(test_n_pin), .ready_pin(ready_pin),
        .hold_pin(hold_pin), .mode_select_input(mode_select_input),
        .maskable_irq_enable(maskable_irq_enable), .instr_boundary(instr_boundary),
        .maskable_irq_type(maskable_irq_type), .wait_instr(wait_instr), .bus_req(bus_req),
        .bus_is_io(bus_is_io), .bus_is_write(bus_is_write),
        .bus_accept(bus_accept), .bus_done(bus_done), .bus_state(bus_state),
        .irq_report(irq_report), .core_stall(core_stall),
        .core_restart(core_restart), .min_mode(min_mode),
        .io_mem_pin(io_mem_pin), .write_n_pin(write_n_pin),
        .bus_grant_output(bus_grant_output));
    cci_sys_model i_cci_sys_model (.clock(clock), .bus_state(bus_state),
        .io_mem_pin(io_mem_pin), .write_n_pin(write_n_pin), .slow(slow),
        .ready_pin(ready_pin), .io_mem_wire(io_mem_wire),
        .write_n_wire(write_n_wire));

    ////////////////////////////////////////////////////////////////
    // Random source; shift-xor keeps the run repeatable.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_cnt(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic cmp_irq(input cci_pkg::cci_irq_t e, input cci_pkg::cci_irq_t g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED irq_report expected %h seen %h", e, g);
        end
    endtask

    // Request a cycle and hold it until the accepting edge passes.
    task automatic bus_op(input logic io, input logic wr, input logic keep);
        bus_req <= 1'h1;
        bus_is_io <= io;
        bus_is_write <= wr;
        @(negedge clock);
        for (int i = 0; i < 60 && bus_accept !== 1'h1; i++) @(negedge clock);
        bq.push_back({io, wr});
        @(posedge clock);
        // A dropped request stays low across one edge before the next call.
        if (!keep) begin
            bus_req <= 1'h0;
            @(posedge clock);
        end
    endtask

    task automatic idle_wait();
        for (int i = 0; i < 60 && bus_state !== cci_pkg::CCI_IDLE; i++) @(negedge clock);
        @(posedge clock);
    endtask

    // One boundary pulse; a taken request is noted with its vector.
    task automatic boundary(input logic tk, input logic nmi, input logic [7:0] t);
        if (tk) iq.push_back({1'h1, nmi, nmi ? 20'h00008 : {10'h000, t, 2'h0}});
        instr_boundary <= 1'h1;
        maskable_irq_type <= t;
        @(posedge clock);
        instr_boundary <= 1'h0;
        repeat (3) @(posedge clock);
    endtask

    task automatic do_reset(input logic mode);
        nrst <= 1'h0;
        mode_select_input <= mode;
        repeat (16) @(posedge clock);
        nrst <= 1'h1;
        repeat (6) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////
    // Watcher: settled outputs are taken at the falling edge.
    always @(negedge clock) begin
        if (!nrst) begin
            wr_lo = 8'h00;
            n_tw = 8'h00;
        end else begin
            // Done rises the cycle after T4, so the finished cycle leaves first.
            if (bus_done === 1'h1 && bq.size() > 0) begin
                cmp_cnt("write low cycles", bq[0].wr ? 8'h02 + n_tw : 8'h00, wr_lo);
                void'(bq.pop_front());
                wr_lo = 8'h00;
                n_tw = 8'h00;
            end
            if (bq.size() > 0 && bus_state !== cci_pkg::CCI_IDLE) begin
                // A T4 that runs straight on already names the next cycle.
                exp_io = (bus_state === cci_pkg::CCI_T4 && bq.size() > 1) ? bq[1].io : bq[0].io;
                cmp_bit("io_mem level", exp_io, io_mem_wire);
            end
            if (write_n_wire === 1'h0) wr_lo++;
            if (bus_state === cci_pkg::CCI_TW) n_tw++;
            if (irq_report.take === 1'h1) begin
                if (iq.size() == 0) cmp_bit("unexpected take", 1'h0, 1'h1);
                else cmp_irq(iq.pop_front(), irq_report);
            end
        end
    end

    initial begin
        clock = 1'h0;
        // High for one third of the 8 ns period, as the clock source gives.
        forever begin
            #5.333 clock = ~clock;
            #2.667 clock = ~clock;
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end

    initial begin
        {nrst, maskable_irq, nmi_pin, hold_pin, maskable_irq_enable, instr_boundary} = '0;
        {wait_instr, bus_req, bus_is_io, bus_is_write, maskable_irq_type, slow} = '0;
        test_n_pin = 1'h1;
        mode_select_input = 1'h1;
        repeat (16) @(posedge clock);
        @(negedge clock);
        cmp_bit("restart in reset", 1'h1, core_restart);
        cmp_bit("io_mem float", 1'h1, io_mem_pin.oe_n);
        @(posedge clock);
        nrst <= 1'h1;
        repeat (6) @(posedge clock);
        cmp_bit("min_mode", 1'h1, min_mode);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            slow <= rnd[1:0];
            bus_op(i[0], i[1], rnd[2]);
        end
        bus_req <= 1'h0;
        idle_wait();
        // A second master takes the bus; pins float and requests wait.
        hold_pin <= 1'h1;
        repeat (4) @(posedge clock);
        bus_req <= 1'h1;
        @(negedge clock);
        cmp_bit("grant", 1'h1, bus_grant_output);
        cmp_bit("accept in grant", 1'h0, bus_accept);
        cmp_cnt("pins floated", 8'h0F, {4'h0, io_mem_pin, write_n_pin});
        @(posedge clock);
        bus_req <= 1'h0;
        hold_pin <= 1'h0;
        repeat (4) @(posedge clock);
        cmp_bit("grant drop", 1'h0, bus_grant_output);
        // Maskable refused, taken, then beaten by the edge request.
        rnd = xs(rnd);
        maskable_irq <= 1'h1;
        repeat (3) @(posedge clock);
        boundary(1'h0, 1'h0, rnd[7:0]);
        maskable_irq_enable <= 1'h1;
        boundary(1'h1, 1'h0, rnd[15:8]);
        nmi_pin <= 1'h1;
        repeat (5) @(posedge clock);
        boundary(1'h1, 1'h1, rnd[7:0]);
        boundary(1'h1, 1'h0, rnd[23:16]);
        {maskable_irq, maskable_irq_enable, nmi_pin} <= 3'h0;
        repeat (3) @(posedge clock);
        nmi_pin <= 1'h1;
        repeat (5) @(posedge clock);
        boundary(1'h1, 1'h1, rnd[7:0]);
        nmi_pin <= 1'h0;
        // Wait-for-test idles until the test pin goes low.
        wait_instr <= 1'h1;
        repeat (5) @(posedge clock);
        cmp_bit("stall", 1'h1, core_stall);
        test_n_pin <= 1'h0;
        repeat (5) @(posedge clock);
        cmp_bit("stall end", 1'h0, core_stall);
        wait_instr <= 1'h0;
        // Reset in mid write abandons the cycle at once.
        slow <= 2'h3;
        bus_op(1'h0, 1'h1, 1'h0);
        for (int i = 0; i < 20 && bus_state !== cci_pkg::CCI_T2; i++) @(negedge clock);
        @(posedge clock);
        nrst <= 1'h0;
        @(negedge clock);
        bq.delete();
        cmp_bit("state idle", 1'h1, bus_state === cci_pkg::CCI_IDLE);
        cmp_bit("write released", 1'h1, write_n_pin.lvl);
        @(posedge clock);
        do_reset(1'h1);
        bus_op(1'h1, 1'h1, 1'h0);
        idle_wait();
        do_reset(1'h0);
        cmp_bit("max mode", 1'h0, min_mode);
        cmp_bit("max float", 1'h1, io_mem_pin.oe_n);
        cmp_cnt("left over", 8'h00, 8'(bq.size() + iq.size()));
        end_sim();
    end
endmodule

/* rtl/cci_consts.svh */
// Named constants for the processor pin-control block: state codes,
// reset values, interrupt vector layout and strap timing.
// Assumes inclusion by the package and the control module by bare name.
`ifndef CCI_CONSTS_SVH
`define CCI_CONSTS_SVH

// Bus state codes, Gray along idle, pre-T4, T1, T2, T3, T4.
`define CCI_ST_IDLE   3'h6
`define CCI_ST_TPRE   3'h4
`define CCI_ST_T1     3'h0
`define CCI_ST_T2     3'h1
`define CCI_ST_T3     3'h3
`define CCI_ST_T4     3'h2
`define CCI_ST_TW     3'h7

// Interrupt type used for the non-maskable request.
`define CCI_NMI_TYPE  8'h02
// Vector table address is the type times four in a 20-bit space.
`define CCI_VEC_PAD   10'h000
`define CCI_VEC_LOW   2'h0

// Strap capture: mode is taken from the synchronised strap at this count.
`define CCI_STRAP_LAST 2'h2
`define CCI_STRAP_DONE 2'h3
`define CCI_STRAP_INC  2'h1

// Pin levels: a floated strobe or status line is held at logic one.
`define CCI_PIN_ONE   1'h1
`define CCI_PIN_ZERO  1'h0

`endif

/* rtl/cci_ctrl.sv */
// Pin-level control logic of an 8-bit-bus processor: interrupt inputs,
// wait-for-test, restart after reset, mode strap, bus cycle sequencing,
// minimum-mode memory-or-I/O status and write strobe, bus hold grant.
// Assumes a core on the same clock that signals instruction boundaries
// and bus requests; all pins arrive asynchronously and are synchronised.
//
// Overview of operation
// - Maskable request is a level sampled at boundaries.
// - Accepted maskable request starts an acknowledge (here it is only reported to the core on irq_report, with no acknowledge cycle).
// - Maskable request honoured only with enable flag set.
// - Maskable request synchronised before sampling.
// - Handler address comes from memory vector table.
// - Wait-for-test idles until test input asserted.
// - Test input synchronised on rising clock edge.
// - Non-maskable request fires on low-to-high edge.
// - Non-maskable input synchronised before edge detect.
// - Reset abandons all activity at once.
// - Execution restarts from reset state on release.
// - Mode strap selects minimum or maximum mode.
// - Status line high for I/O, low for memory.
// - Status valid from preceding T4 through final T4.
// - Status line floats at logic one during grant.
// - Write strobe low in T2, T3 and wait states.
// - Write strobe floats at logic one during grant.
// - Bus request answered by grant when bus free.
`timescale 1ns/1ps
`include "cci_consts.svh"

module cci_ctrl (
    // Clock and reset.
    input  wire logic                clock,
    input  wire logic                nrst,
    // Asynchronous device pins.
    input  wire logic                maskable_irq,
    input  wire logic                nmi_pin,
    input  wire logic                test_n_pin,
    input  wire logic                ready_pin,
    input  wire logic                hold_pin,
    input  wire logic                mode_select_input,
    // Core side, same clock.
    input  wire logic                maskable_irq_enable,
    input  wire logic                instr_boundary,
    input  wire logic [7:0]          maskable_irq_type,
    input  wire logic                wait_instr,
    input  wire logic                bus_req,
    input  wire logic                bus_is_io,
    input  wire logic                bus_is_write,
    // Core side results.
    output logic                     bus_accept,
    output logic                     bus_done,
    output cci_pkg::cci_bus_st_t     bus_state,
    output cci_pkg::cci_irq_t        irq_report,
    output logic                     core_stall,
    output logic                     core_restart,
    output logic                     min_mode,
    // Bus control pins.
    output cci_pkg::cci_pin_t        io_mem_pin,
    output cci_pkg::cci_pin_t        write_n_pin,
    output logic                     bus_grant_output
);

    ////////////////////////////////////////////////////////////////////////////
    // State register and its next value.

    cci_pkg::cci_state_t q;          // Registered state.
    cci_pkg::cci_state_t d;          // Next state.
    logic                nmi_edge;   // Rising edge seen on synchronised NMI.
    logic                take_ok;    // Sequencer can accept a new cycle now.
    logic                in_strobe;  // Next state is T2, T3 or a wait state.

    // Reset value of the whole state: bus idle, pins floated high,
    // restart pulse pending so the core starts from its reset state.
    localparam cci_pkg::cci_state_t CCI_RST = '{
        bus_st:    cci_pkg::CCI_IDLE,
        io_mem:    '{lvl: `CCI_PIN_ONE, oe_n: `CCI_PIN_ONE},
        wr_n:      '{lvl: `CCI_PIN_ONE, oe_n: `CCI_PIN_ONE},
        restart:   `CCI_PIN_ONE,
        default:   '0
    };

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Sync stages: the first flop of each pair is read only by the second.
    // A new cycle may only start while idle or while leaving T3/wait
    // with ready, so that the status line is already valid in the T4
    // that precedes it.
    always_comb begin
        d = q;
        // Two-flop synchronisers for every pin input.
        d.maskable_irq_sy  = {q.maskable_irq_sy[0], maskable_irq};
        d.nmi_sy   = {q.nmi_sy[0], nmi_pin};
        d.test_sy  = {q.test_sy[0], test_n_pin};
        d.rdy_sy   = {q.rdy_sy[0], ready_pin};
        d.hold_sy  = {q.hold_sy[0], hold_pin};
        d.mode_sy  = {q.mode_sy[0], mode_select_input};
        d.nmi_prev = q.nmi_sy[1];
        d.restart  = `CCI_PIN_ZERO;
        d.done     = `CCI_PIN_ZERO;

        // Mode strap is caught once, after the synchroniser has filled.
        if (q.strap_cnt == `CCI_STRAP_LAST) begin
            d.min_mode = q.mode_sy[1];
        end
        if (q.strap_cnt != `CCI_STRAP_DONE) begin
            d.strap_cnt = q.strap_cnt + `CCI_STRAP_INC;
        end

        // Acceptance point: idle without a hold, or T3/wait with ready.
        take_ok = 1'b0;
        case (q.bus_st)
            cci_pkg::CCI_IDLE: begin
                take_ok = !q.grant && !q.hold_sy[1];
            end
            cci_pkg::CCI_T3, cci_pkg::CCI_TW: begin
                take_ok = q.rdy_sy[1] && !q.nxt_pend;
            end
            default: begin
                take_ok = 1'b0;
            end
        endcase
        bus_accept = bus_req && take_ok;

        // Bus cycle sequencer.
        case (q.bus_st)
            cci_pkg::CCI_IDLE: begin
                if (bus_accept) begin
                    d.bus_st     = cci_pkg::CCI_TPRE;
                    d.cyc_io     = bus_is_io;
                    d.cyc_wr     = bus_is_write;
                    d.io_mem.lvl = bus_is_io;
                end
            end
            cci_pkg::CCI_TPRE: begin
                d.bus_st = cci_pkg::CCI_T1;
            end
            cci_pkg::CCI_T1: begin
                d.bus_st = cci_pkg::CCI_T2;
            end
            cci_pkg::CCI_T2: begin
                d.bus_st = cci_pkg::CCI_T3;
            end
            cci_pkg::CCI_T3, cci_pkg::CCI_TW: begin
                // Wait states repeat while the synchronised ready is low.
                if (q.rdy_sy[1]) begin
                    d.bus_st = cci_pkg::CCI_T4;
                    if (bus_accept) begin
                        d.nxt_pend   = 1'b1;
                        d.nxt_io     = bus_is_io;
                        d.nxt_wr     = bus_is_write;
                        d.io_mem.lvl = bus_is_io;
                    end
                end else begin
                    d.bus_st = cci_pkg::CCI_TW;
                end
            end
            cci_pkg::CCI_T4: begin
                d.done = 1'b1;
                if (q.nxt_pend) begin
                    d.bus_st   = cci_pkg::CCI_T1;
                    d.cyc_io   = q.nxt_io;
                    d.cyc_wr   = q.nxt_wr;
                    d.nxt_pend = 1'b0;
                end else begin
                    d.bus_st = cci_pkg::CCI_IDLE;
                end
            end
            default: begin
                d.bus_st = cci_pkg::CCI_IDLE;
            end
        endcase

        // Hold grant: given only from idle, dropped when the request falls.
        if (q.grant) begin
            d.grant = q.hold_sy[1];
        end else if (q.bus_st == cci_pkg::CCI_IDLE && q.hold_sy[1]
                     && !bus_req) begin
            d.grant = 1'b1;
        end

        // Write strobe follows the next state, so the pin, which comes
        // from a flop, lines up with the registered bus state.
        in_strobe = (d.bus_st == cci_pkg::CCI_T2) || (d.bus_st == cci_pkg::CCI_T3)
                    || (d.bus_st == cci_pkg::CCI_TW);
        d.wr_n.lvl = !(in_strobe && d.cyc_wr);

        // Float both lines at logic one during grant or in maximum mode.
        d.io_mem.oe_n = d.grant || !d.min_mode;
        d.wr_n.oe_n   = d.grant || !d.min_mode;
        if (d.grant) begin
            d.io_mem.lvl = `CCI_PIN_ONE;
            d.wr_n.lvl   = `CCI_PIN_ONE;
        end

        // Interrupt decision at an instruction boundary.
        nmi_edge   = q.nmi_sy[1] && !q.nmi_prev;
        d.irq.take = 1'b0;
        if (instr_boundary) begin
            if (q.nmi_pend) begin
                // No enable term here: the NMI cannot be masked.
                d.irq.take     = 1'b1;
                d.irq.is_nmi   = 1'b1;
                d.irq.vec_addr = {`CCI_VEC_PAD, `CCI_NMI_TYPE, `CCI_VEC_LOW};
                d.nmi_pend     = 1'b0;
            end else if (q.maskable_irq_sy[1] && maskable_irq_enable) begin
                d.irq.take     = 1'b1;
                d.irq.is_nmi   = 1'b0;
                d.irq.vec_addr = {`CCI_VEC_PAD, maskable_irq_type, `CCI_VEC_LOW};
            end
        end
        // An edge arriving as the pending flag is consumed is kept.
        if (nmi_edge) begin
            d.nmi_pend = 1'b1;
        end

        // Wait-for-test idles while the active-low test pin is high.
        d.stall = wait_instr && q.test_sy[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset is asynchronous so activity stops at once, mid-cycle or not.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= CCI_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state register except bus_accept.

    assign bus_done         = q.done;
    assign bus_state        = q.bus_st;
    assign irq_report       = q.irq;
    assign core_stall       = q.stall;
    assign core_restart     = q.restart;
    assign min_mode         = q.min_mode;
    assign io_mem_pin       = q.io_mem;
    assign write_n_pin      = q.wr_n;
    assign bus_grant_output = q.grant;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cci_cb @(posedge clock); endclocking
    default disable iff (!nrst);

    wr_strobe_a: assert property (
        !q.wr_n.lvl |-> q.cyc_wr && (q.bus_st == cci_pkg::CCI_T2
            || q.bus_st == cci_pkg::CCI_T3 || q.bus_st == cci_pkg::CCI_TW))
        else $error("Write strobe low outside T2, T3 or wait state.");

    bus_seq_a: assert property (
        q.bus_st == cci_pkg::CCI_T1 |=> q.bus_st == cci_pkg::CCI_T2
            ##1 q.bus_st == cci_pkg::CCI_T3)
        else $error("Bus cycle did not run T1, T2, T3.");

    wait_ins_a: assert property (
        (q.bus_st == cci_pkg::CCI_T3 || q.bus_st == cci_pkg::CCI_TW) && !q.rdy_sy[1]
            |=> q.bus_st == cci_pkg::CCI_TW)
        else $error("No wait state while ready was low.");

    iomem_hold_a: assert property (
        (q.bus_st == cci_pkg::CCI_T1 || q.bus_st == cci_pkg::CCI_T2)
            |=> $stable(q.io_mem.lvl) && q.io_mem.lvl == q.cyc_io)
        else $error("Status line moved inside a bus cycle.");

    grant_float_a: assert property (
        q.grant |-> q.io_mem.oe_n && q.wr_n.oe_n && q.io_mem.lvl && q.wr_n.lvl)
        else $error("Lines not floated high during grant.");

    nmi_catch_a: assert property (
        $rose(q.nmi_sy[1]) |=> ##[0:1] q.nmi_pend)
        else $error("NMI edge not latched.");

    nmi_first_a: assert property (
        instr_boundary && q.nmi_pend |=> q.irq.take && q.irq.is_nmi
            && q.irq.vec_addr == {`CCI_VEC_PAD, `CCI_NMI_TYPE, `CCI_VEC_LOW})
        else $error("Pending NMI not taken first.");

    maskable_irq_mask_a: assert property (
        instr_boundary && !q.nmi_pend && !maskable_irq_enable |=> !q.irq.take)
        else $error("Maskable request taken while disabled.");

    test_idle_a: assert property (
        wait_instr && q.test_sy[1] |=> core_stall)
        else $error("No idle while test input not asserted.");

    // Once the synchronised test input is low the idle ends next cycle.
    test_go_a: assert property (
        !q.test_sy[1] |=> !core_stall)
        else $error("Still idle after test input asserted.");

    // The strobe must also be present in every write T2, T3 and wait
    // state; the check above alone would pass a pin stuck high.
    wr_present_a: assert property (
        q.cyc_wr && !q.grant && (q.bus_st == cci_pkg::CCI_T2
            || q.bus_st == cci_pkg::CCI_T3 || q.bus_st == cci_pkg::CCI_TW)
            |-> !q.wr_n.lvl)
        else $error("Write strobe high inside a write cycle.");

    // Status is already valid in the cycle that precedes T1.
    iomem_pre_a: assert property (
        q.bus_st == cci_pkg::CCI_TPRE |-> q.io_mem.lvl == q.cyc_io)
        else $error("Status line not valid before T1.");

    // With no follow-on cycle the status still names this cycle in T4.
    iomem_t4_a: assert property (
        q.bus_st == cci_pkg::CCI_T4 && !q.nxt_pend |-> q.io_mem.lvl == q.cyc_io)
        else $error("Status line changed before the final T4.");

    // A synchronised and enabled maskable request is taken at a boundary.
    maskable_irq_take_a: assert property (
        instr_boundary && !q.nmi_pend && q.maskable_irq_sy[1] && maskable_irq_enable
            |=> q.irq.take && !q.irq.is_nmi)
        else $error("Enabled maskable request not taken.");

    // Grant is only ever given while the bus is idle.
    grant_idle_a: assert property (
        $rose(q.grant) |-> q.bus_st == cci_pkg::CCI_IDLE)
        else $error("Grant given during a bus cycle.");

    // Maximum mode leaves both lines floated.
    max_float_a: assert property (
        !q.min_mode |-> q.io_mem.oe_n && q.wr_n.oe_n)
        else $error("Lines driven in maximum mode.");

    // The restart pulse lasts only the first cycle after release.
    restart_a: assert property (
        core_restart |=> !core_restart)
        else $error("Restart pulse longer than one cycle.");

    wr_cycle_c:   cover property (!q.wr_n.lvl && q.bus_st == cci_pkg::CCI_TW);
    nmi_take_c:   cover property (q.irq.take && q.irq.is_nmi);
    maskable_irq_take_c:  cover property (q.irq.take && !q.irq.is_nmi);
    grant_c:      cover property ($fell(q.grant));
    b2b_c:        cover property (q.bus_st == cci_pkg::CCI_T4 && q.nxt_pend);

endmodule

/* rtl/cci_pkg.sv */
// Types shared by the processor pin-control block.
// Assumes the constants header sits beside it in rtl/.
`include "cci_consts.svh"

package cci_pkg;

    // Bus cycle sequencer states.
    typedef enum logic [2:0] {
        CCI_IDLE = `CCI_ST_IDLE,
        CCI_TPRE = `CCI_ST_TPRE,
        CCI_T1   = `CCI_ST_T1,
        CCI_T2   = `CCI_ST_T2,
        CCI_T3   = `CCI_ST_T3,
        CCI_T4   = `CCI_ST_T4,
        CCI_TW   = `CCI_ST_TW
    } cci_bus_st_t;

    // A tri-state output pin: level and active-low output enable.
    typedef struct packed {
        logic lvl;
        logic oe_n;
    } cci_pin_t;

    // Interrupt acceptance report towards the core.
    typedef struct packed {
        logic        take;
        logic        is_nmi;
        logic [19:0] vec_addr;
    } cci_irq_t;

    // Whole state of the control module.
    typedef struct packed {
        cci_bus_st_t bus_st;
        logic        cyc_io;
        logic        cyc_wr;
        logic        nxt_pend;
        logic        nxt_io;
        logic        nxt_wr;
        logic        grant;
        cci_pin_t    io_mem;
        cci_pin_t    wr_n;
        logic [1:0]  maskable_irq_sy;
        logic [1:0]  nmi_sy;
        logic        nmi_prev;
        logic        nmi_pend;
        logic [1:0]  test_sy;
        logic [1:0]  rdy_sy;
        logic [1:0]  hold_sy;
        logic [1:0]  mode_sy;
        logic        min_mode;
        logic [1:0]  strap_cnt;
        logic        restart;
        logic        stall;
        logic        done;
        cci_irq_t    irq;
    } cci_state_t;

endpackage
